// *** src/rtc_wdog_top.sv ***
`timescale 1ns/1ns
`include "rtc_wdog_cfg.svh"
module rtc_wdog_top #(
    parameter int unsigned TICK_DIV = `CLK_HZ / `BASE_HZ
) (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic       alarm_event_i,
    output logic [7:0]      reg_rdata_o,
    output logic            interrupt_output_o,
    output logic            wdog_running_o
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // One compare shared by the write and read decoders
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
        return (addr == target);
    endfunction : addr_is

    // Write-one-keeps, write-zero-clears, so clearing one flag never disturbs another
    function automatic logic and_clear(input logic old_v, input logic wr_v);
        return old_v && wr_v;
    endfunction : and_clear

    // Flag register image; spare positions stay zero
    function automatic logic [7:0] pack_flags(input logic tick, input logic wdog, input logic alarm);
        logic [7:0] v;
        v             = 8'h00;
        v[`FLG_TICK]  = tick;
        v[`FLG_WDOG]  = wdog;
        v[`FLG_ALARM] = alarm;
        return v;
    endfunction : pack_flags

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    logic wr_ctrl;
    logic wr_flags;
    logic wr_wdctl;
    logic wr_wdval;

    // Addresses are distinct, so the chain order carries no priority
    always_comb
    begin
        wr_ctrl  = 1'b0;
        wr_flags = 1'b0;
        wr_wdctl = 1'b0;
        wr_wdval = 1'b0;
        if (reg_wr_i && addr_is(reg_addr_i, `ADDR_CTRL))
        begin
            wr_ctrl = 1'b1;
        end
        else if (reg_wr_i && addr_is(reg_addr_i, `ADDR_FLAGS))
        begin
            wr_flags = 1'b1;
        end
        else if (reg_wr_i && addr_is(reg_addr_i, `ADDR_WD_CTL))
        begin
            wr_wdctl = 1'b1;
        end
        else if (reg_wr_i && addr_is(reg_addr_i, `ADDR_WD_VAL))
        begin
            wr_wdval = 1'b1;
        end
    end

    // ----------------------------------------
    // Tick sources and watchdog counter
    // ----------------------------------------
    logic       base_tick;
    logic [3:0] rate_tick;
    logic       sec_tick;
    logic       min_tick;

    // Tick chain runs from reset whatever the watchdog settings are
    rtc_tick_gen #(
        .TICK_DIV (TICK_DIV)
    ) u_tick (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .base_tick_o (base_tick),
        .rate_tick_o (rate_tick),
        .sec_tick_o  (sec_tick),
        .min_tick_o  (min_tick)
    );

    wdog_if #(.W(8)) wd ();

    rtc_wdog_counter u_cnt (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .wd     (wd.cnt)
    );

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic                    sec_en_q, sec_en_d;
    logic                    min_en_q, min_en_d;
    logic                    wd_en_q, wd_en_d;
    logic                    pulse_sel_q, pulse_sel_d;
    // A select change mid-count applies from the next tick of the new rate
    rtc_wdog_pkg::wdog_sel_e sel_q, sel_d;

    always_comb
    begin
        sec_en_d    = sec_en_q;
        min_en_d    = min_en_q;
        wd_en_d     = wd_en_q;
        pulse_sel_d = pulse_sel_q;
        sel_d       = sel_q;
        if (wr_ctrl)
        begin
            sec_en_d = reg_wdata_i[`CTL_SEC_EN];
            min_en_d = reg_wdata_i[`CTL_MIN_EN];
        end
        if (wr_wdctl)
        begin
            wd_en_d     = reg_wdata_i[`WDC_EN];
            pulse_sel_d = reg_wdata_i[`WDC_PULSE];
            sel_d       = rtc_wdog_pkg::wdog_sel_e'(reg_wdata_i[`WDC_SEL_HI:`WDC_SEL_LO]);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sec_en_q    <= 1'b0;
            min_en_q    <= 1'b0;
            wd_en_q     <= 1'b0;
            pulse_sel_q <= 1'b0;
            sel_q       <= rtc_wdog_pkg::wdog_sel_e'(`WDC_SEL_RST);
        end
        else
        begin
            sec_en_q    <= sec_en_d;
            min_en_q    <= min_en_d;
            wd_en_q     <= wd_en_d;
            pulse_sel_q <= pulse_sel_d;
            sel_q       <= sel_d;
        end
    end

    // Counter hookup; a load takes effect in the cycle after the write
    always_comb
    begin
        wd.load  = wr_wdval;
        wd.value = reg_wdata_i;
        wd.tick  = rate_tick[sel_q];
    end

    // ----------------------------------------
    // Event flags
    // ----------------------------------------
    logic tick_flag_q, tick_flag_d;
    logic wdog_timeout_flag_q, wdog_timeout_flag_d;
    logic alarm_match_flag_q, alarm_match_flag_d;
    logic tick_set;
    logic wdog_clear;

    // Hardware set wins over a same-cycle clear
    always_comb
    begin
        tick_set   = (sec_tick && sec_en_q) || (min_tick && min_en_q);
        wdog_clear = wr_wdval || (wr_flags && !reg_wdata_i[`FLG_WDOG]);
        tick_flag_d         = tick_flag_q;
        wdog_timeout_flag_d = wdog_timeout_flag_q;
        alarm_match_flag_d  = alarm_match_flag_q;
        if (wr_flags)
        begin
            tick_flag_d        = and_clear(tick_flag_q, reg_wdata_i[`FLG_TICK]);
            alarm_match_flag_d = and_clear(alarm_match_flag_q, reg_wdata_i[`FLG_ALARM]);
        end
        if (wdog_clear)
        begin
            wdog_timeout_flag_d = 1'b0;
        end
        if (tick_set)
        begin
            tick_flag_d = 1'b1;
        end
        if (alarm_event_i)
        begin
            alarm_match_flag_d = 1'b1;
        end
        if (wd.expire)
        begin
            wdog_timeout_flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tick_flag_q         <= 1'b0;
            wdog_timeout_flag_q <= 1'b0;
            alarm_match_flag_q  <= 1'b0;
        end
        else
        begin
            tick_flag_q         <= tick_flag_d;
            wdog_timeout_flag_q <= wdog_timeout_flag_d;
            alarm_match_flag_q  <= alarm_match_flag_d;
        end
    end

    // ----------------------------------------
    // Interrupt output
    // ----------------------------------------
    logic [3:0] pulse_cnt_q, pulse_cnt_d;
    logic       int_q, int_d;
    logic       tick_int;
    logic       wdog_int;

    // Pulse length counted in 64 Hz ticks so it does not depend on clk rate
    always_comb
    begin
        pulse_cnt_d = pulse_cnt_q;
        if (tick_set)
        begin
            pulse_cnt_d = `PULSE_TICKS;
        end
        else if (base_tick && pulse_cnt_q != '0)
        begin
            pulse_cnt_d = pulse_cnt_q - 1'b1;
        end
        tick_int = pulse_sel_q ? (pulse_cnt_q != '0) : tick_flag_q;
        // Flag outlives a cleared enable; enabling later raises the pin at once
        wdog_int = wd_en_q && wdog_timeout_flag_q;
        int_d    = tick_int || wdog_int;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pulse_cnt_q <= '0;
            int_q       <= 1'b0;
        end
        else
        begin
            pulse_cnt_q <= pulse_cnt_d;
            int_q       <= int_d;
        end
    end

    assign interrupt_output_o = int_q;
    assign wdog_running_o     = wd.running;

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Registered read data holds until the next read strobe
    logic [7:0] rdata_q, rdata_d;

    always_comb
    begin
        rdata_d = rdata_q;
        if (reg_rd_i)
        begin
            rdata_d = 8'h00;
            if (addr_is(reg_addr_i, `ADDR_CTRL))
            begin
                rdata_d[`CTL_SEC_EN] = sec_en_q;
                rdata_d[`CTL_MIN_EN] = min_en_q;
            end
            else if (addr_is(reg_addr_i, `ADDR_FLAGS))
            begin
                rdata_d = pack_flags(tick_flag_q, wdog_timeout_flag_q, alarm_match_flag_q);
            end
            else if (addr_is(reg_addr_i, `ADDR_WD_CTL))
            begin
                rdata_d[`WDC_EN]                  = wd_en_q;
                rdata_d[`WDC_PULSE]               = pulse_sel_q;
                rdata_d[`WDC_SEL_HI:`WDC_SEL_LO]  = sel_q;
            end
            // Value register and unmapped addresses read as zero
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rdata_q <= 8'h00;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

endmodule : rtc_wdog_top

// *** include/rtc_wdog_cfg.svh ***
`ifndef RTC_WDOG_CFG_SVH
`define RTC_WDOG_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ          32'h02FA_F080
`define BASE_HZ         32'h0000_0040
`define BASE_CNT_W      12
`define DIV_4HZ_MSB     3
`define DIV_QHZ_MSB     7
`define DIV_64TH_MSB    11
`define TICKS_PER_SEC   6'h3F
`define SECS_PER_MIN    6'h3B
`define PULSE_TICKS     4'h1

// ----------------------------------------
// Register map
// ----------------------------------------
`define ADDR_CTRL       8'h00
`define ADDR_FLAGS      8'h01
`define ADDR_WD_CTL     8'h35
`define ADDR_WD_VAL     8'h36

// ----------------------------------------
// Field positions, reset values and the watchdog stop count
// ----------------------------------------
`define CTL_SEC_EN      0
`define CTL_MIN_EN      1
`define WDC_EN          7
`define WDC_PULSE       5
`define WDC_SEL_HI      1
`define WDC_SEL_LO      0
`define FLG_TICK        7
`define FLG_WDOG        6
`define FLG_ALARM       4
`define WDC_SEL_RST     2'h3
`define WD_CNT_STOP     8'h01

`endif

// *** include/rtc_wdog_pkg.sv ***
package rtc_wdog_pkg;

    typedef enum logic [1:0]
    {
        SEL_64HZ   = 2'h0,
        SEL_4HZ    = 2'h1,
        SEL_QHZ    = 2'h2,
        SEL_64THHZ = 2'h3
    } wdog_sel_e;

    typedef enum logic
    {
        WD_IDLE = 1'h0,
        WD_RUN  = 1'h1
    } wdog_state_e;

endpackage : rtc_wdog_pkg

// *** include/wdog_if.sv ***
`timescale 1ns/1ns
interface wdog_if #(parameter int unsigned W = 8);
    logic         load;
    logic [W-1:0] value;
    logic         tick;
    logic         expire;
    logic         running;

    modport ctrl (output load, output value, output tick, input expire, input running);
    modport cnt  (input load, input value, input tick, output expire, output running);
endinterface : wdog_if

// *** src/rtc_tick_gen.sv ***
`timescale 1ns/1ns
`include "rtc_wdog_cfg.svh"
module rtc_tick_gen #(
    parameter int unsigned TICK_DIV = `CLK_HZ / `BASE_HZ
) (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    output logic            base_tick_o,
    output logic [3:0]      rate_tick_o,
    output logic            sec_tick_o,
    output logic            min_tick_o
);
    localparam int unsigned PW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

    logic [PW-1:0]          pre_q, pre_d;
    logic [`BASE_CNT_W-1:0] base_q, base_d;
    logic [5:0]             sub_q, sub_d;
    logic [5:0]             sec_q, sec_d;
    logic                   hit;
    logic                   sec_hit;

    // ----------------------------------------
    // Free-running 64 Hz chain
    // ----------------------------------------
    always_comb
    begin
        hit     = (pre_q == PW'(TICK_DIV - 1));
        sec_hit = hit && (sub_q == `TICKS_PER_SEC);
        pre_d   = hit ? '0 : pre_q + 1'b1;
        base_d  = hit ? base_q + 1'b1 : base_q;
        sub_d   = hit ? ((sub_q == `TICKS_PER_SEC) ? '0 : sub_q + 1'b1) : sub_q;
        sec_d   = sec_hit ? ((sec_q == `SECS_PER_MIN) ? '0 : sec_q + 1'b1) : sec_q;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pre_q  <= '0;
            base_q <= '0;
            sub_q  <= '0;
            sec_q  <= '0;
        end
        else
        begin
            pre_q  <= pre_d;
            base_q <= base_d;
            sub_q  <= sub_d;
            sec_q  <= sec_d;
        end
    end

    // Strobes indexed by select code
    assign base_tick_o    = hit;
    assign rate_tick_o[0] = hit;
    assign rate_tick_o[1] = hit && (base_q[`DIV_4HZ_MSB:0] == '1);
    assign rate_tick_o[2] = hit && (base_q[`DIV_QHZ_MSB:0] == '1);
    assign rate_tick_o[3] = hit && (base_q[`DIV_64TH_MSB:0] == '1);
    assign sec_tick_o     = sec_hit;
    assign min_tick_o     = sec_hit && (sec_q == `SECS_PER_MIN);

endmodule : rtc_tick_gen

// *** src/rtc_wdog_counter.sv ***
`timescale 1ns/1ns
`include "rtc_wdog_cfg.svh"
module rtc_wdog_counter (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    wdog_if.cnt       wd
);
    rtc_wdog_pkg::wdog_state_e state_q, state_d;
    logic [7:0]                count_q, count_d;
    logic                      expire_q, expire_d;

    always_comb
    begin
        state_d  = state_q;
        count_d  = count_q;
        expire_d = 1'b0;
        if (wd.load)
        begin
            count_d = wd.value;
            state_d = (wd.value > `WD_CNT_STOP) ? rtc_wdog_pkg::WD_RUN : rtc_wdog_pkg::WD_IDLE;
        end
        else if (state_q == rtc_wdog_pkg::WD_RUN && wd.tick)
        begin
            count_d = count_q - 1'b1;
            if (count_d == `WD_CNT_STOP)
            begin
                state_d  = rtc_wdog_pkg::WD_IDLE;
                expire_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q  <= rtc_wdog_pkg::WD_IDLE;
            count_q  <= '0;
            expire_q <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            count_q  <= count_d;
            expire_q <= expire_d;
        end
    end

    assign wd.expire  = expire_q;
    assign wd.running = (state_q == rtc_wdog_pkg::WD_RUN);

endmodule : rtc_wdog_counter

// *** sim/host_model.sv ***
`timescale 1ns/1ns
module host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // Released lines show the inverse so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        @(negedge clk_i);
        d = rdata_i;
    endtask : rd
endmodule : host_model

// *** sim/rtc_wdog_monitor.sv ***
`timescale 1ns/1ns
module rtc_wdog_monitor #(
    parameter int unsigned TICK_DIV = 4
) (
    input wire logic       clk_i,
    input wire logic       rstn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic       alarm_event_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       interrupt_output_o,
    input wire logic       wdog_running_o
);
    logic        wd_en_q;
    logic        pulse_q;
    logic [1:0]  sel_q;
    logic [1:0]  ten_q;
    logic [7:0]  n_q;
    int unsigned run_q;
    int unsigned dv;
    wire         ld = reg_wr_i && reg_addr_i == 8'h36;
    wire         src = wd_en_q || ten_q != 2'h0;

    assign dv = TICK_DIV << (4 * sel_q);

    // Shadows of settings; period check assumes select is steady while running
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wd_en_q <= 1'b0;
            pulse_q <= 1'b0;
            sel_q <= 2'h3;
            ten_q <= 2'h0;
            n_q <= 8'h00;
            run_q <= 0;
        end
        else
        begin
            run_q <= ld ? 0 : run_q + 1;
            if (ld)
                n_q <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == 8'h00)
                ten_q <= reg_wdata_i[1:0];
            if (reg_wr_i && reg_addr_i == 8'h35)
            begin
                wd_en_q <= reg_wdata_i[7];
                pulse_q <= reg_wdata_i[5];
                sel_q <= reg_wdata_i[1:0];
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_val_write_only: assert property (
        reg_rd_i && reg_addr_i == 8'h36 ##1 !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("value register read back nonzero");
    a_flag_spare_zero: assert property (
        reg_rd_i && reg_addr_i == 8'h01 ##1 !reg_rd_i |=> (reg_rdata_o & 8'h2F) == 8'h00)
        else $error("spare flag bits not zero");
    a_low_load_stops: assert property (
        ld && reg_wdata_i <= 8'h01 ##1 !reg_wr_i |=> !wdog_running_o)
        else $error("counter runs after load of 0 or 1");
    a_load_starts: assert property (
        ld && reg_wdata_i > 8'h02 |=> wdog_running_o)
        else $error("counter idle after load");
    a_no_reload: assert property (
        $rose(wdog_running_o) |-> $past(ld && reg_wdata_i > 8'h01))
        else $error("counter started without load");
    a_expiry_int: assert property (
        $fell(wdog_running_o) && !$past(reg_wr_i) && wd_en_q |-> ##[1:3] (interrupt_output_o || reg_wr_i))
        else $error("no interrupt after expiry");
    a_period_span: assert property (
        $fell(wdog_running_o) && !$past(reg_wr_i)
        |-> run_q + 2 >= (int'(n_q) - 2) * dv && run_q <= (int'(n_q) - 1) * dv + 4)
        else $error("watchdog period out of range");
    a_rise_has_src: assert property (
        $rose(interrupt_output_o) |-> src || $past(src, 2))
        else $error("interrupt rose with sources disabled");
    // An expiry landing on the clearing write sets the flag again, so it is left out
    a_flag_zero_drop: assert property (
        reg_wr_i && reg_addr_i == 8'h01 && reg_wdata_i[7:6] == 2'h0 && !pulse_q && ten_q == 2'h0
        && $past(ten_q, 2) == 2'h0 && !wdog_running_o && !$fell(wdog_running_o)
        |-> ##2 !interrupt_output_o)
        else $error("interrupt held after flag clear");

    cover property ($fell(wdog_running_o) && !$past(reg_wr_i));
    cover property ($rose(interrupt_output_o) && wd_en_q);
    cover property (reg_rd_i && reg_addr_i == 8'h36);
endmodule : rtc_wdog_monitor

bind rtc_wdog_top rtc_wdog_monitor #(.TICK_DIV(TICK_DIV)) monitor_u (.clk_i(clk_i), .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .alarm_event_i(alarm_event_i), .reg_rdata_o(reg_rdata_o), .interrupt_output_o(interrupt_output_o),
    .wdog_running_o(wdog_running_o));

// *** sim/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    localparam int unsigned TD = 4;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        alarm_event_i = 1'b0;
    logic [7:0]  reg_addr_i;
    logic [7:0]  reg_wdata_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [7:0]  reg_rdata_o;
    logic        interrupt_output_o;
    logic        wdog_running_o;
    logic [7:0]  rv;
    logic [15:0] lfsr_q = 16'h6A14;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cyc = 0;

    always #10 clk_i = ~clk_i;

    rtc_wdog_top #(.TICK_DIV(TD)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .alarm_event_i(alarm_event_i),
        .reg_rdata_o(reg_rdata_o), .interrupt_output_o(interrupt_output_o), .wdog_running_o(wdog_running_o));
    host_model host_u (.clk_i(clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
        .wr_o(reg_wr_i), .rd_o(reg_rd_i));

    function automatic logic [7:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q[7:0];
    endfunction : rnd

    function automatic logic [7:0] flags(input logic t, input logic w, input logic a);
        return {t, w, 1'b0, a, 4'h0};
    endfunction : flags

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    // Expiry time allows one tick of phase slack
    task automatic run_wd(input logic [1:0] s, input logic [7:0] n, input logic en);
        int c;
        int t;
        c = 0;
        t = TD << (4 * s);
        host_u.wr(8'h35, {en, 5'h00, s});
        host_u.wr(8'h36, n);
        chk({7'h0, wdog_running_o}, 8'h01);
        while (wdog_running_o === 1'b1 && c < 20000)
        begin
            @(negedge clk_i);
            c++;
        end
        chk({7'h0, c >= (int'(n) - 2) * t && c <= (int'(n) - 1) * t + 4}, 8'h01);
        repeat (3) @(negedge clk_i);
        chk({7'h0, interrupt_output_o}, {7'h0, en});
    endtask : run_wd

    task automatic count_rises(input logic [7:0] ctl, input int len, input int exp);
        int k;
        logic p;
        k = 0;
        host_u.wr(8'h00, ctl);
        // A pulse launched on the write edge itself must die out before counting
        repeat (8) @(negedge clk_i);
        p = interrupt_output_o;
        repeat (len)
        begin
            @(negedge clk_i);
            k += int'(interrupt_output_o && !p);
            p = interrupt_output_o;
        end
        chk(8'(k), 8'(exp));
    endtask : count_rises

    task automatic alarm();
        @(negedge clk_i);
        alarm_event_i = 1'b1;
        @(negedge clk_i);
        alarm_event_i = 1'b0;
    endtask : alarm

    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_mismatch++;
            summarize();
        end
    end

    initial
    begin
        repeat (6) @(negedge clk_i);
        rstn_i = 1'b1;
        chk({6'h0, interrupt_output_o, wdog_running_o}, 8'h00);
        host_u.rd(8'h01, rv);
        chk(rv, flags(0, 0, 0));
        host_u.rd(8'h35, rv);
        chk(rv, 8'h03);
        for (int s = 0; s < 4; s++)
            run_wd(2'(s), 8'h02, 1'b0);
        host_u.rd(8'h01, rv);
        chk(rv, flags(0, 1, 0));
        host_u.wr(8'h01, 8'h40);
        host_u.rd(8'h01, rv);
        chk(rv, flags(0, 1, 0));
        host_u.wr(8'h01, 8'h00);
        host_u.rd(8'h01, rv);
        chk(rv, flags(0, 0, 0));
        for (int i = 0; i < 3; i++)
        begin
            run_wd(2'h0, 8'h03 + (rnd() & 8'h0F), 1'b1);
            repeat (20) @(negedge clk_i);
            chk({7'h0, wdog_running_o}, 8'h00);
            host_u.wr(8'h36, i < 2 ? 8'(i) : 8'hC8);
            @(negedge clk_i);
            chk({6'h0, interrupt_output_o, wdog_running_o}, {7'h0, i == 2});
            host_u.rd(8'h36, rv);
            chk(rv, 8'h00);
        end
        host_u.wr(8'h36, 8'h01);
        host_u.wr(8'h35, 8'h00);
        host_u.wr(8'h00, 8'h01);
        repeat (260) @(negedge clk_i);
        chk({7'h0, interrupt_output_o}, 8'h01);
        host_u.wr(8'h00, 8'h00);
        alarm();
        host_u.rd(8'h01, rv);
        chk(rv, flags(1, 0, 1));
        host_u.wr(8'h01, 8'h80);
        host_u.rd(8'h01, rv);
        chk(rv, flags(1, 0, 0));
        alarm();
        host_u.wr(8'h01, 8'h10);
        host_u.rd(8'h01, rv);
        chk(rv, flags(0, 0, 1));
        host_u.wr(8'h01, 8'h00);
        host_u.wr(8'h35, 8'h20);
        count_rises(8'h01, 512, 2);
        count_rises(8'h00, 512, 0);
        host_u.wr(8'h35, 8'h23);
        host_u.wr(8'h36, 8'h05);
        count_rises(8'h02, 15360, 1);
        summarize();
    end
endmodule : testbench
